//--- include/adsp_pkg.sv
// constants for the converter sequencing and power control block
// assumes one 20 MHz core clock and a plain strobe register port
package adsp_pkg;
  // ===========================================================
  // register offsets
  localparam logic [3:0] ADSP_REG_CTRL_A = 4'h0;
  localparam logic [3:0] ADSP_REG_CTRL_B = 4'h1;
  localparam logic [3:0] ADSP_REG_CTRL_C = 4'h2;
  localparam logic [3:0] ADSP_REG_STATUS = 4'h3;
  localparam logic [3:0] ADSP_REG_BUF0 = 4'h8;
  // ===========================================================
  // control a fields
  localparam int ADSP_A_ON = 15;
  localparam int ADSP_A_IDLE_STOP = 13;
  localparam int ADSP_A_TRIG_LSB = 5;
  localparam int ADSP_A_SIMSEL = 3;
  localparam int ADSP_A_AUTO = 2;
  localparam int ADSP_A_SAMPLE = 1;
  localparam int ADSP_A_DONE = 0;
  // control b fields
  localparam int ADSP_B_SHCNT_LSB = 8;
  localparam int ADSP_B_CPI_LSB = 2;
  localparam int ADSP_B_IRQ_EN = 0;
  // control c fields
  localparam int ADSP_C_SAMT_LSB = 8;
  localparam int ADSP_C_RC = 7;
  localparam int ADSP_C_DIV_LSB = 0;
  // ===========================================================
  // values
  localparam logic [2:0] ADSP_TRIG_AUTO = 3'h7;
  localparam logic [15:0] ADSP_CTRL_RESET = 16'h0000;
  localparam logic [3:0] ADSP_CONV_TADS = 4'hC;
  localparam logic [3:0] ADSP_RESULT_TADS = 4'hB;
  // instruction cycle delay before an rc clock conversion
  localparam logic [1:0] ADSP_RC_DELAY = 2'h1;
endpackage

//--- core/adsp_ctrl.sv
// sequencing, timing and power control for a 10-bit converter
// assumes the conversion core returns a result on i_core_result and that
// register accesses come as one-cycle strobes on the core clock
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module adsp_ctrl
  import adsp_pkg::*;
#(
  parameter int NUM_BUF = 16
)(
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_sleep,
  input wire logic i_idle,
  input wire logic i_rc_tick,
  input wire logic [9:0] i_core_result,
  output logic [15:0] o_rdata,
  output logic o_sample,
  output logic [1:0] o_sh_channel,
  output logic o_convert,
  output logic o_powered,
  output logic o_irq,
  output logic o_wake
);
  // ===========================================================
  // reset release
  logic rst_s1_q;
  logic rst_s2_q;
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  wire rstn = rst_s2_q;

  // ===========================================================
  // sequencer states
  typedef enum logic [1:0] {
    ADSP_IDLE = 2'b00,
    ADSP_WAIT = 2'b01,
    ADSP_SAMPLE_BIT = 2'b10,
    ADSP_CONV = 2'b11
  } adsp_state_t;

  logic [15:0] ctrl_a_q, ctrl_a_d;
  logic [15:0] ctrl_b_q, ctrl_b_d;
  logic [15:0] ctrl_c_q, ctrl_c_d;
  adsp_state_t st_q, st_d;
  logic [5:0] div_q, div_d;
  logic [4:0] tad_q, tad_d;
  logic [1:0] shc_q, shc_d;
  logic [3:0] cnt_q, cnt_d;
  logic [3:0] bidx_q, bidx_d;
  logic off_q, off_d;
  logic irq_q, irq_d;
  logic wake_q, wake_d;
  logic [15:0] rdata_d;
  logic [9:0] buf_mem [NUM_BUF];

  wire on_bit = ctrl_a_q[ADSP_A_ON];
  wire [2:0] trig = ctrl_a_q[ADSP_A_TRIG_LSB +: 3];
  wire auto_sample_bit = ctrl_a_q[ADSP_A_AUTO];
  wire [1:0] sh_cnt = ctrl_b_q[ADSP_B_SHCNT_LSB +: 2];
  wire [3:0] cpi = ctrl_b_q[ADSP_B_CPI_LSB +: 4];
  wire [4:0] samt = ctrl_c_q[ADSP_C_SAMT_LSB +: 5];
  wire rc_sel = ctrl_c_q[ADSP_C_RC];
  wire [5:0] divider = ctrl_c_q[ADSP_C_DIV_LSB +: 6];
  // sleep freezes the clock unless rc clock selected; idle per stop bit
  wire halted = (i_sleep && !rc_sel) ||
                (i_idle && ctrl_a_q[ADSP_A_IDLE_STOP]);
  wire active = on_bit && !off_q && !halted;
  // conversion clock period: (divider+1) core clocks, or rc ticks
  wire tad_tick = rc_sel ? i_rc_tick : (div_q == divider);
  wire last_sh = (shc_q == sh_cnt);
  wire conv_end = (st_q == ADSP_CONV) && tad_tick &&
                  (tad_q == 5'(ADSP_RESULT_TADS));

  // ===========================================================
  // next state
  always_comb
  begin
    ctrl_a_d = ctrl_a_q;
    ctrl_b_d = ctrl_b_q;
    ctrl_c_d = ctrl_c_q;
    st_d = st_q;
    div_d = (tad_tick || st_q == ADSP_IDLE) ? 6'h00 : div_q + 6'h01;
    tad_d = tad_q;
    shc_d = shc_q;
    cnt_d = cnt_q;
    bidx_d = bidx_q;
    off_d = off_q;
    irq_d = 1'b0;
    wake_d = 1'b0;
    rdata_d = 16'h0000;
    if (i_rd)
    begin
      case (i_addr)
        ADSP_REG_CTRL_A: rdata_d = ctrl_a_q;
        ADSP_REG_CTRL_B: rdata_d = ctrl_b_q;
        ADSP_REG_CTRL_C: rdata_d = ctrl_c_q;
        ADSP_REG_STATUS: rdata_d = {12'h000, bidx_q};
        default:
          if (i_addr >= ADSP_REG_BUF0)
            rdata_d = {6'h00, buf_mem[i_addr - ADSP_REG_BUF0]};
      endcase
    end
    if (i_wr)
    begin
      case (i_addr)
        ADSP_REG_CTRL_A: ctrl_a_d = i_wdata;
        ADSP_REG_CTRL_B: ctrl_b_d = i_wdata;
        ADSP_REG_CTRL_C: ctrl_c_d = i_wdata;
        default: ;
      endcase
      if (i_addr == ADSP_REG_CTRL_A && !i_wdata[ADSP_A_ON])
        off_d = 1'b0;
    end
    if (!on_bit || halted)
    begin
      // stopped: abandon any conversion, registers keep values
      st_d = ADSP_IDLE;
      div_d = 6'h00;
    end
    else if (active)
    begin
      case (st_q)
        ADSP_IDLE:
          if (auto_sample_bit || ctrl_a_q[ADSP_A_SAMPLE])
          begin
            st_d = rc_sel ? ADSP_WAIT : ADSP_SAMPLE_BIT;
            tad_d = 5'h00;
            shc_d = 2'h0;
            ctrl_a_d[ADSP_A_SAMPLE] = 1'b1;
          end
        ADSP_WAIT:
          if (tad_d == 5'h00 && 2'(tad_q) >= ADSP_RC_DELAY - 2'h1)
            st_d = ADSP_SAMPLE_BIT;
        ADSP_SAMPLE_BIT:
        begin
          if (tad_tick)
            tad_d = tad_q + 5'h01;
          // auto trigger ends sampling after the programmed periods
          if (trig == ADSP_TRIG_AUTO)
          begin
            if (tad_tick && tad_q + 5'h01 >= samt)
            begin
              st_d = ADSP_CONV;
              tad_d = 5'h00;
              if (shc_q == 2'h0)
                ctrl_a_d[ADSP_A_SAMPLE] = 1'b0;
            end
          end
          else if (!ctrl_a_q[ADSP_A_SAMPLE])
          begin
            st_d = ADSP_CONV;
            tad_d = 5'h00;
          end
        end
        ADSP_CONV:
        begin
          if (tad_tick)
            tad_d = tad_q + 5'h01;
          if (conv_end)
          begin
            ctrl_a_d[ADSP_A_DONE] = 1'b1;
            bidx_d = bidx_q + 4'h1;
            tad_d = 5'h00;
            if (cnt_q == cpi)
            begin
              cnt_d = 4'h0;
              bidx_d = 4'h0;
              irq_d = ctrl_b_q[ADSP_B_IRQ_EN];
            end
            else
              cnt_d = cnt_q + 4'h1;
            if (i_sleep)
            begin
              if (ctrl_b_q[ADSP_B_IRQ_EN])
                wake_d = 1'b1;
              else
                off_d = 1'b1;
              st_d = ADSP_IDLE;
            end
            else if (!last_sh)
            begin
              // next channel was acquiring during this conversion
              shc_d = shc_q + 2'h1;
              st_d = (trig == ADSP_TRIG_AUTO) ? ADSP_SAMPLE_BIT : ADSP_CONV;
            end
            else
            begin
              shc_d = 2'h0;
              st_d = auto_sample_bit ? ADSP_SAMPLE_BIT : ADSP_IDLE;
              ctrl_a_d[ADSP_A_SAMPLE] = auto_sample_bit;
            end
          end
        end
        default: st_d = ADSP_IDLE;
      endcase
    end
  end

  // ===========================================================
  // registers
  always_ff @(posedge i_core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_a_q <= ADSP_CTRL_RESET;
      ctrl_b_q <= ADSP_CTRL_RESET;
      ctrl_c_q <= ADSP_CTRL_RESET;
      st_q <= ADSP_IDLE;
      div_q <= 6'h00;
      tad_q <= 5'h00;
      shc_q <= 2'h0;
      cnt_q <= 4'h0;
      bidx_q <= 4'h0;
      off_q <= 1'b0;
      irq_q <= 1'b0;
      wake_q <= 1'b0;
      o_rdata <= 16'h0000;
      o_sample <= 1'b0;
      o_sh_channel <= 2'h0;
      o_convert <= 1'b0;
      o_powered <= 1'b0;
    end
    else
    begin
      ctrl_a_q <= ctrl_a_d;
      ctrl_b_q <= ctrl_b_d;
      ctrl_c_q <= ctrl_c_d;
      st_q <= st_d;
      div_q <= div_d;
      tad_q <= tad_d;
      shc_q <= shc_d;
      cnt_q <= cnt_d;
      bidx_q <= bidx_d;
      off_q <= off_d;
      irq_q <= irq_d;
      wake_q <= wake_d;
      o_rdata <= rdata_d;
      o_sample <= (st_d == ADSP_SAMPLE_BIT);
      o_sh_channel <= shc_d;
      o_convert <= (st_d == ADSP_CONV);
      o_powered <= on_bit && !off_d;
    end
  end

  // result buffers have no reset so a reset leaves them alone
  always_ff @(posedge i_core_clk)
  begin
    if (conv_end && active)
      buf_mem[bidx_q] <= i_core_result;
  end

  assign o_irq = irq_q;
  assign o_wake = wake_q;
endmodule

//--- testbench/adsp_ctrl_properties.sv
// port checks for the converter control block
// assumes the bind below onto adsp_ctrl, a single core clock domain
`timescale 1ns/1ps
module adsp_ctrl_properties
  import adsp_pkg::*;
#(
  parameter int NUM_BUF = 16
)(
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_sleep,
  input wire logic i_idle,
  input wire logic i_rc_tick,
  input wire logic [9:0] i_core_result,
  input wire logic [15:0] o_rdata,
  input wire logic o_sample,
  input wire logic [1:0] o_sh_channel,
  input wire logic o_convert,
  input wire logic o_powered,
  input wire logic o_irq,
  input wire logic o_wake
);
  // ==========================================
  // rc select as last written
  logic rc_q;
  logic rc_d;
  always_comb
    rc_d = (i_wr && i_addr == ADSP_REG_CTRL_C) ? i_wdata[ADSP_C_RC] : rc_q;
  always_ff @(posedge i_core_clk or negedge i_rstn)
    if (!i_rstn)
      rc_q <= 1'h0;
    else
      rc_q <= rc_d;
  // ==========================================
  // properties
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rstn);
  sequence on_wr;
    i_wr && i_addr == ADSP_REG_CTRL_A;
  endsequence
  power_on_a: assert property (on_wr ##0 (i_wdata[ADSP_A_ON] && !i_sleep)
    |-> ##[1:2] o_powered) else $error("converter did not power up");
  power_off_a: assert property (on_wr ##0 !i_wdata[ADSP_A_ON]
    |-> ##[1:2] !o_powered) else $error("converter stayed powered");
  off_quiet_a: assert property (!o_powered ##1 !o_powered
    |-> !o_convert) else $error("conversion while off");
  sleep_abort_a: assert property ((i_sleep && !rc_q) ##1 i_sleep
    |-> !o_convert) else $error("conversion kept in sleep");
  sample_first_a: assert property ($rose(o_convert)
    |-> $past(o_sample)) else $error("conversion without sampling");
  irq_pulse_a: assert property (o_irq |=> !o_irq)
    else $error("interrupt longer than one cycle");
  wake_sleep_a: assert property (o_wake
    |-> $past(i_sleep) ##1 !o_wake) else $error("bad wake pulse");
  reset_off_a: assert property ($rose(i_rstn)
    |-> !o_powered ##1 !o_powered) else $error("powered out of reset");
endmodule
bind adsp_ctrl adsp_ctrl_properties #(.NUM_BUF(NUM_BUF)) i_props (
  .i_core_clk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .i_sleep,
  .i_idle, .i_rc_tick, .i_core_result, .o_rdata, .o_sample,
  .o_sh_channel, .o_convert, .o_powered, .o_irq, .o_wake);

//--- testbench/adsp_core_model.sv
// behavioural conversion core on the far side of the control block
// assumes the result is taken while o_convert is high
`timescale 1ns/1ps
module adsp_core_model #(
  parameter logic [9:0] RESULT = 10'h2A5
)(
  input wire logic i_core_clk,
  input wire logic i_convert,
  input wire logic [1:0] i_sh_channel,
  output logic [9:0] o_result
);
  // ==========================================
  // result lines
  // they toggle between conversions so a stale capture cannot pass
  initial
    o_result = 10'h000;
  always @(posedge i_core_clk)
    o_result <= i_convert ? RESULT ^ {8'h00, i_sh_channel} : ~o_result;
endmodule

//--- testbench/tb_top.sv
// self-checking bench for the converter control block
// assumes the checker bind and the core model from this folder
`timescale 1ns/1ps
module tb_top
  import adsp_pkg::*;
();
  // ==========================================
  // signals
  localparam logic [9:0] RES = 10'h2A5;
  localparam logic [15:0] RUN = 16'h80E4;
  logic i_core_clk = 1'h0;
  logic i_rstn = 1'h0;
  logic i_wr = 1'h0;
  logic i_rd = 1'h0;
  logic i_sleep = 1'h0;
  logic i_idle = 1'h0;
  logic i_rc_tick = 1'h0;
  logic [3:0] i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic [9:0] i_core_result;
  logic [15:0] o_rdata, rv;
  logic [1:0] o_sh_channel;
  logic o_sample, o_convert, o_powered, o_irq, o_wake;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int irq_cnt = 0;
  int conv_cnt = 0;
  int n;
  adsp_ctrl i_adsp_ctrl (.i_core_clk, .i_rstn, .i_addr, .i_wdata, .i_wr,
    .i_rd, .i_sleep, .i_idle, .i_rc_tick, .i_core_result, .o_rdata,
    .o_sample, .o_sh_channel, .o_convert, .o_powered, .o_irq, .o_wake);
  adsp_core_model i_adsp_core_model (.i_core_clk, .i_convert(o_convert),
    .i_sh_channel(o_sh_channel), .o_result(i_core_result));
  always #25 i_core_clk = ~i_core_clk;
  always @(posedge o_irq) irq_cnt++;
  always @(posedge o_convert) conv_cnt++;
  // the run needs a few hundred cycles
  always @(posedge i_core_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      test_done();
    end
  end
  // ==========================================
  // helpers
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'h1;
    @(posedge i_core_clk);
    i_wr <= 1'h0;
  endtask
  task rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd <= 1'h1;
    @(posedge i_core_clk);
    i_rd <= 1'h0;
    #1 d = o_rdata;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function logic pick(input bit s);
    return s ? o_convert : o_sample;
  endfunction
  // waits for the chosen phase, then counts its cycles
  task len(input bit s, output int c);
    c = 0;
    for (int k = 0; k < 300 && pick(s) !== 1'h1; k++)
      @(posedge i_core_clk) #1;
    while (pick(s) === 1'h1 && c < 300)
    begin
      @(posedge i_core_clk) #1;
      c++;
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task t_reset;
    rd(ADSP_REG_CTRL_A, rv);
    chk(rv, ADSP_CTRL_RESET);
    rd(4'h5, rv);
    chk(rv, 16'h0000);
  endtask
  task t_auto;
    wr(ADSP_REG_CTRL_C, 16'h0201);
    wr(ADSP_REG_CTRL_B, 16'h0005);
    wr(ADSP_REG_CTRL_A, RUN);
    len(1'h0, n);
    chk(16'(n), 16'h0004);
    chk({14'h0, o_sh_channel}, 16'h0000);
    len(1'h1, n);
    chk(16'(n), 16'h0018);
    chk({15'h0, o_sample}, 16'h0001);
    chk(16'(irq_cnt), 16'h0000);
    rd(ADSP_REG_BUF0, rv);
    chk(rv, {6'h00, RES});
    rd(ADSP_REG_CTRL_A, rv);
    chk({15'h0, rv[ADSP_A_DONE]}, 16'h0001);
    len(1'h1, n);
    repeat (3) @(posedge i_core_clk);
    chk(16'(irq_cnt), 16'h0001);
  endtask
  task t_sleep;
    for (n = 0; n < 100 && o_convert !== 1'h1; n++)
      @(posedge i_core_clk);
    i_sleep <= 1'h1;
    repeat (3) @(posedge i_core_clk);
    #1 chk({15'h0, o_convert}, 16'h0000);
    @(posedge i_core_clk);
    i_sleep <= 1'h0;
    rd(ADSP_REG_CTRL_A, rv);
    chk(rv & 16'hA0EC, RUN);
  endtask
  task t_idle;
    i_idle <= 1'h1;
    n = conv_cnt;
    repeat (100) @(posedge i_core_clk);
    chk({15'h0, conv_cnt - n > 2}, 16'h0001);
    wr(ADSP_REG_CTRL_A, RUN | 16'h2000);
    repeat (30) @(posedge i_core_clk);
    n = conv_cnt;
    repeat (100) @(posedge i_core_clk);
    chk(16'(conv_cnt - n), 16'h0000);
    i_idle <= 1'h0;
  endtask
  task t_off_rst;
    wr(ADSP_REG_CTRL_A, 16'h0000);
    repeat (3) @(posedge i_core_clk);
    #1 chk({14'h0, o_powered, o_sample}, 16'h0000);
    wr(ADSP_REG_CTRL_A, RUN);
    // settling: a full sampling phase passes before anything is judged
    len(1'h0, n);
    i_rstn <= 1'h0;
    repeat (2) @(posedge i_core_clk);
    i_rstn <= 1'h1;
    repeat (3) @(posedge i_core_clk);
    chk({15'h0, o_powered}, 16'h0000);
    rd(ADSP_REG_BUF0, rv);
    chk(rv, {6'h00, RES});
    rd(ADSP_REG_CTRL_A, rv);
    chk(rv, ADSP_CTRL_RESET);
  endtask
  // rc clock keeps converting through sleep, one tick per core clock
  task t_rc;
    wr(ADSP_REG_CTRL_C, 16'h0280);
    wr(ADSP_REG_CTRL_B, 16'h0001);
    i_rc_tick <= 1'h1;
    i_sleep <= 1'h1;
    wr(ADSP_REG_CTRL_A, RUN);
    @(posedge i_core_clk) #1;
    chk({15'h0, o_sample}, 16'h0000);
    @(posedge i_core_clk) #1;
    chk({15'h0, o_sample}, 16'h0001);
    for (n = 0; n < 100 && o_wake !== 1'h1; n++)
      @(posedge i_core_clk) #1;
    chk({15'h0, o_wake}, 16'h0001);
    wr(ADSP_REG_CTRL_B, 16'h0000);
    for (n = 0; n < 100 && o_powered !== 1'h0; n++)
      @(posedge i_core_clk) #1;
    chk({15'h0, o_powered}, 16'h0000);
    rd(ADSP_REG_CTRL_A, rv);
    chk({15'h0, rv[ADSP_A_ON]}, 16'h0001);
    i_sleep <= 1'h0;
    i_rc_tick <= 1'h0;
  endtask
  initial
  begin
    repeat (12) @(posedge i_core_clk);
    i_rstn <= 1'h1;
    repeat (3) @(posedge i_core_clk);
    t_reset();
    t_auto();
    t_sleep();
    t_idle();
    t_off_rst();
    t_rc();
    test_done();
  end
endmodule
